/* File: design/acfz_pkg.sv */
`default_nettype none
package acfz_pkg;
  localparam int CLK_MHZ = 10;
  // time figures in ns
  localparam int WAKE_NS = 2200;
  localparam int ZC_WAIT_NS = 2200;
  localparam int DLH_FIX_NS = 40;
  localparam int ZC_HIGH_NS = 50;
  localparam int BLANK_LO_NS = 130;
  localparam int BLANK_HI_NS = 200;
  localparam int MINON_LO_NS = 65;
  localparam int MINON_HI_NS = 90;
  localparam int CSF_HI_NS = 2000;
  localparam int CSF_LO_NS = 1000;
  localparam int CSF_LO_ALT_NS = 2000;
  function automatic int cyc_up(input int ns);
    int c;
    c = (ns * CLK_MHZ + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction
  function automatic int cyc_dn(input int ns);
    int c;
    c = (ns * CLK_MHZ) / 1000;
    return (c < 1) ? 1 : c;
  endfunction
  localparam logic [9:0] WAKE_CYC = 10'(cyc_up(WAKE_NS));
  localparam logic [9:0] ZC_CYC = 10'(cyc_dn(ZC_WAIT_NS));
  localparam logic [9:0] DLH_CYC = 10'(cyc_up(DLH_FIX_NS));
  localparam logic [9:0] ZCH_CYC = 10'(cyc_up(ZC_HIGH_NS));
  localparam logic [9:0] BLANK_LO_CYC = 10'(cyc_up(BLANK_LO_NS));
  localparam logic [9:0] BLANK_HI_CYC = 10'(cyc_up(BLANK_HI_NS));
  localparam logic [9:0] MINON_LO_CYC = 10'(cyc_up(MINON_LO_NS));
  localparam logic [9:0] MINON_HI_CYC = 10'(cyc_up(MINON_HI_NS));
  localparam logic [9:0] CSF_HI_CYC = 10'(cyc_dn(CSF_HI_NS));
  localparam logic [9:0] CSF_LO_CYC = 10'(cyc_dn(CSF_LO_NS));
  localparam logic [9:0] CSF_LO_ALT_CYC = 10'(cyc_dn(CSF_LO_ALT_NS));
  // line feed-forward: knee in uA, extension = tzmin*(knee-i)*7/(5*knee)
  localparam logic [9:0] LINE_KNEE_UA = 10'h29a;
  localparam logic [20:0] EXT_MUL = 21'h000007;
  localparam logic [20:0] EXT_DIV = 21'h000d02;
  // high-side on-time tuning
  localparam logic [7:0] TDM_MIN = 8'h04;
  localparam logic [7:0] TDM_MAX = 8'hf0;
  localparam logic [7:0] TDM_RST = 8'h04;
  localparam logic [3:0] STEP_RST = 4'h8;
  // register offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_PKT = 8'h04;
  localparam logic [7:0] ADDR_TZMIN = 8'h08;
  localparam logic [7:0] ADDR_STS = 8'h0c;
  localparam logic [7:0] ADDR_MASK = 8'h10;
  localparam logic [7:0] ADDR_TDM = 8'h14;
  localparam logic [7:0] ADDR_INFO = 8'h18;
  // reset values and fields
  localparam logic [2:0] CTRL_RST = 3'h0;
  localparam logic [3:0] PKT_RST = 4'h2;
  localparam logic [7:0] TZMIN_RST = 8'h03;
  localparam int CTRL_EN = 0;
  localparam int CTRL_BURST = 1;
  localparam int CTRL_LP = 2;
  localparam int ST_FAULT = 0;
  localparam int ST_PKT = 1;
  localparam int ST_SETL = 2;
  localparam int ST_ZCTO = 3;
  typedef enum logic [3:0] {
    S_IDLE, S_WAKE, S_ZWAIT, S_LON, S_DLH, S_HON, S_DHL, S_NEXT, S_TAIL
  } acfz_state_e;
endpackage
`default_nettype wire

/* File: design/acfz_sequencer.sv */
`default_nettype none
module acfz_sequencer
  import acfz_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic power_stage_sel,
  input wire logic aux_zero_crossing,
  input wire logic switch_node_sense,
  input wire logic cs_trip,
  input wire logic demag_time_resistor_low,
  input wire logic [9:0] line_sense_current,
  output logic driver_enable,
  output logic low_side_gate,
  output logic high_side_gate,
  output logic zero_voltage_threshold_high,
  output logic sense_blank,
  output logic irq
);
  import acfz_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [4:0] pin_raw;
  logic [4:0] pin_s1_q;
  logic [4:0] pin_s2_q;
  assign pin_raw = {demag_time_resistor_low, cs_trip, switch_node_sense, aux_zero_crossing, power_stage_sel};
  for (genvar i = 0; i < 5; i++) begin : g_sync
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        pin_s1_q[i] <= 1'b0;
        pin_s2_q[i] <= 1'b0;
      end else if (ce) begin
        pin_s1_q[i] <= pin_raw[i];
        pin_s2_q[i] <= pin_s1_q[i];
      end
    end
  end
  logic zc;
  logic sw_below;
  logic cs_hit;
  logic rdm_low;
  assign zc = pin_s2_q[1];
  assign sw_below = pin_s2_q[2];
  assign cs_hit = pin_s2_q[3];
  assign rdm_low = pin_s2_q[4];

  ////////////////////////////////////////////////////////////////////////////
  // start-up capture of the power-stage select
  logic [1:0] boot_q;
  logic sel_q;
  logic sel_ok_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_q <= 2'h0;
      sel_q <= 1'b0;
      sel_ok_q <= 1'b0;
    end else if (ce && !sel_ok_q) begin
      boot_q <= boot_q + 2'h1;
      if (boot_q == 2'h3) begin
        sel_q <= pin_s2_q[0];
        sel_ok_q <= 1'b1;
      end
    end
  end

  logic [9:0] blank_cyc;
  logic [9:0] minon_cyc;
  logic [9:0] csf_cyc;
  assign blank_cyc = sel_q ? BLANK_HI_CYC : BLANK_LO_CYC;
  assign minon_cyc = sel_q ? MINON_HI_CYC : MINON_LO_CYC;
  assign csf_cyc = sel_q ? CSF_HI_CYC : (rdm_low ? CSF_LO_CYC : CSF_LO_ALT_CYC);

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [2:0] ctrl_q;
  logic [3:0] pkt_q;
  logic [7:0] tzmin_q;
  logic [3:0] sts_q;
  logic [3:0] sts_d;
  logic [3:0] mask_q;
  logic [3:0] ev;
  logic setl_q;
  logic [7:0] tdm_q;
  logic [3:0] step_q;
  logic [9:0] tz;
  logic wr_en;
  logic setup;
  assign setup = psel && !penable;
  assign wr_en = psel && penable && pwrite && pready;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= CTRL_RST;
      pkt_q <= PKT_RST;
      tzmin_q <= TZMIN_RST;
      mask_q <= 4'h0;
    end else if (ce && wr_en) begin
      if (paddr == ADDR_CTRL) ctrl_q <= pwdata[2:0];
      if (paddr == ADDR_PKT) pkt_q <= pwdata[3:0];
      if (paddr == ADDR_TZMIN) tzmin_q <= pwdata[7:0];
      if (paddr == ADDR_MASK) mask_q <= pwdata[3:0];
    end
  end

  // sticky status, set beats write-one-clear
  always_comb begin
    sts_d = sts_q;
    if (wr_en && paddr == ADDR_STS) sts_d = sts_d & ~pwdata[3:0];
    sts_d = sts_d | ev;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sts_q <= 4'h0;
      irq <= 1'b0;
    end else if (ce) begin
      sts_q <= sts_d;
      irq <= |(sts_q & mask_q);
    end
  end

  logic [31:0] rd_d;
  logic bad_d;
  always_comb begin
    rd_d = 32'h0;
    bad_d = 1'b0;
    unique case (paddr)
      ADDR_CTRL: rd_d = {29'h0, ctrl_q};
      ADDR_PKT: rd_d = {28'h0, pkt_q};
      ADDR_TZMIN: rd_d = {24'h0, tzmin_q};
      ADDR_STS: rd_d = {28'h0, sts_q};
      ADDR_MASK: rd_d = {28'h0, mask_q};
      ADDR_TDM: rd_d = {20'h0, step_q, tdm_q};
      ADDR_INFO: rd_d = {20'h0, tz, sel_ok_q, sel_q};
      default: bad_d = 1'b1;
    endcase
  end

  // apb answer: ready in first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else if (ce) begin
      pready <= setup;
      pslverr <= setup && bad_d;
      if (setup) prdata <= pwrite ? 32'h0 : rd_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // line feed-forward and dead-time
  logic [9:0] line_q;
  logic [9:0] line_gap;
  logic [20:0] ext_prod;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) line_q <= LINE_KNEE_UA;
    else if (ce && low_side_gate) line_q <= line_sense_current;
  end
  assign line_gap = (line_q < LINE_KNEE_UA) ? LINE_KNEE_UA - line_q : 10'h0;
  assign ext_prod = 21'(tzmin_q) * 21'(line_gap) * EXT_MUL;
  assign tz = 10'(tzmin_q) + 10'(ext_prod / EXT_DIV);

  ////////////////////////////////////////////////////////////////////////////
  // sequencer
  acfz_state_e state_q;
  acfz_state_e state_d;
  logic [9:0] cnt_q;
  logic [9:0] cnt_d;
  logic cnt_rst;
  logic [3:0] pulses_q;
  logic zseen_q;
  logic below_q;
  logic tune;
  logic go;
  logic lp;
  logic last;
  assign lp = ctrl_q[CTRL_LP];
  assign go = ctrl_q[CTRL_EN] && sel_ok_q && !sts_q[ST_FAULT];
  assign last = ctrl_q[CTRL_BURST] ? (pulses_q + 4'h1 == pkt_q) : !ctrl_q[CTRL_EN];

  always_comb begin
    state_d = state_q;
    cnt_rst = 1'b0;
    tune = 1'b0;
    ev[ST_FAULT] = 1'b0;
    ev[ST_SETL] = setl_q;
    ev[ST_PKT] = 1'b0;
    ev[ST_ZCTO] = 1'b0;
    unique case (state_q)
      S_IDLE: begin
        if (go && (!ctrl_q[CTRL_BURST] || cnt_q >= WAKE_CYC - 10'h1)) state_d = S_WAKE;
      end
      S_WAKE: begin
        if (cnt_q == WAKE_CYC - 10'h1) state_d = S_ZWAIT;
      end
      S_ZWAIT: begin
        if (zc) begin
          state_d = S_LON;
        end else if (cnt_q == ZC_CYC - 10'h1) begin
          state_d = S_LON;
          ev[ST_ZCTO] = 1'b1;
        end
      end
      S_LON: begin
        if (cnt_q == csf_cyc - 10'h1) begin
          state_d = S_IDLE;
          ev[ST_FAULT] = 1'b1;
        end else if (cs_hit && cnt_q >= blank_cyc && (!lp || cnt_q >= minon_cyc - 10'h1)) begin
          state_d = S_DLH;
        end
      end
      S_DLH: begin
        if (lp) begin
          state_d = S_NEXT;
        end else if (!sel_q) begin
          if (cnt_q == DLH_CYC - 10'h1) state_d = S_HON;
        end else if (!zseen_q) begin
          if (zc || cnt_q == ZC_CYC - 10'h1) cnt_rst = 1'b1;
        end else if (cnt_q == ZCH_CYC - 10'h1) begin
          state_d = S_HON;
        end
      end
      S_HON: begin
        if (cnt_q == 10'(tdm_q) - 10'h1) state_d = S_DHL;
      end
      S_DHL: begin
        if (cnt_q == tz - 10'h1) begin
          tune = 1'b1;
          if (last) state_d = S_TAIL;
          else if (lp) state_d = S_ZWAIT;
          else state_d = S_LON;
        end
      end
      S_NEXT: begin
        if (last) state_d = S_TAIL;
        else if (lp) state_d = S_ZWAIT;
        else state_d = S_LON;
      end
      S_TAIL: begin
        if (zc || cnt_q == ZC_CYC - 10'h1) begin
          state_d = S_IDLE;
          ev[ST_PKT] = 1'b1;
        end
      end
    endcase
  end

  assign cnt_d = (state_d != state_q || cnt_rst) ? 10'h0 : (cnt_q == 10'h3ff ? cnt_q : cnt_q + 10'h1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= S_IDLE;
      cnt_q <= 10'h0;
      pulses_q <= 4'h0;
      zseen_q <= 1'b0;
      below_q <= 1'b0;
    end else if (ce) begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      if (state_q == S_IDLE) pulses_q <= 4'h0;
      else if (state_q == S_NEXT || tune) pulses_q <= pulses_q + 4'h1;
      zseen_q <= (state_q == S_DLH) && (zseen_q || cnt_rst);
      // watch for switch node below threshold
      below_q <= (state_q == S_DHL) && (below_q || sw_below);
    end
  end

  // gate outputs from flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      driver_enable <= 1'b0;
      low_side_gate <= 1'b0;
      high_side_gate <= 1'b0;
      sense_blank <= 1'b0;
      zero_voltage_threshold_high <= 1'b0;
    end else if (ce) begin
      driver_enable <= state_d != S_IDLE;
      low_side_gate <= state_d == S_LON;
      high_side_gate <= state_d == S_HON;
      sense_blank <= (state_d == S_LON) && (cnt_d < blank_cyc);
      zero_voltage_threshold_high <= sel_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // high-side on-time tuning
  logic dir_up;
  logic have_dir_q;
  logic last_up_q;
  logic [8:0] tdm_up;
  logic [8:0] tdm_dn;
  assign dir_up = !(below_q || sw_below);
  assign tdm_up = 9'(tdm_q) + 9'(step_q);
  assign tdm_dn = 9'(tdm_q) - 9'(step_q);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tdm_q <= TDM_RST;
      step_q <= STEP_RST;
      have_dir_q <= 1'b0;
      last_up_q <= 1'b0;
      setl_q <= 1'b0;
    end else if (ce) begin
      setl_q <= 1'b0;
      if (tune) begin
        have_dir_q <= 1'b1;
        last_up_q <= dir_up;
        // halve step on reversal, then dither
        if (have_dir_q && dir_up != last_up_q) begin
          if (step_q != 4'h1) step_q <= step_q >> 1;
          else setl_q <= 1'b1;
        end
        if (dir_up) tdm_q <= (tdm_up > 9'(TDM_MAX)) ? TDM_MAX : tdm_up[7:0];
        else tdm_q <= (tdm_dn[8] || tdm_dn < 9'(TDM_MIN)) ? TDM_MIN : tdm_dn[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [9:0] run_age_q;
  logic [9:0] on_age_q;
  logic started_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_age_q <= 10'h0;
      on_age_q <= 10'h0;
      started_q <= 1'b0;
    end else if (ce) begin
      run_age_q <= !driver_enable ? 10'h0 : (run_age_q == 10'h3ff ? run_age_q : run_age_q + 10'h1);
      on_age_q <= low_side_gate ? on_age_q + 10'h1 : 10'h0;
      started_q <= driver_enable && (started_q || low_side_gate);
    end
  end

  gates_need_run_a: assert property ((low_side_gate || high_side_gate) |-> driver_enable)
    else $error("gate active with driver disabled");
  gates_excl_a: assert property ($fell(low_side_gate) |-> !high_side_gate)
    else $error("high side turned on with no dead-time");
  wake_wait_a: assert property ($rose(low_side_gate) && !started_q |-> run_age_q >= WAKE_CYC)
    else $error("first pulse before wake-up time");
  zc_bound_a: assert property ($rose(low_side_gate) && !started_q |-> run_age_q <= WAKE_CYC + ZC_CYC + 10'h1)
    else $error("first pulse later than crossing timeout");
  thr_hold_a: assert property (sel_ok_q && $past(sel_ok_q) |=> $stable(zero_voltage_threshold_high) && $stable(sel_q))
    else $error("select derived value changed");
  blank_start_a: assert property ($rose(low_side_gate) |-> sense_blank ##1 (sense_blank || !low_side_gate))
    else $error("blanking too short");
  max_on_a: assert property (low_side_gate |-> on_age_q < csf_cyc)
    else $error("low-side pulse beyond limit");
  fixed_dt_a: assert property ($fell(low_side_gate) && !sel_q && !lp && !sts_q[ST_FAULT] && ce |=> high_side_gate)
    else $error("fixed dead-time not one cycle");
  tdm_range_a: assert property (tdm_q >= TDM_MIN && tdm_q <= TDM_MAX)
    else $error("high-side on-time out of range");
  tune_when_a: assert property ($changed(tdm_q) |-> $past(state_q) == S_DHL)
    else $error("on-time changed outside dead-time end");
  line_hold_a: assert property (!low_side_gate |=> $stable(line_q))
    else $error("line sample taken with low side off");
  hon_zc_a: assert property ($rose(high_side_gate) && sel_q |-> $past(zseen_q))
    else $error("high side on before crossing");

  pkt_done_c: cover property (ev[ST_PKT]);
  settle_c: cover property (ev[ST_SETL]);
  fault_c: cover property (ev[ST_FAULT]);
  high_pulse_c: cover property ($fell(high_side_gate) ##[1:40] $rose(low_side_gate));
endmodule // acfz_sequencer
`default_nettype wire

/* File: testbench/acfz_drv_model.sv */
`default_nettype none
module acfz_drv_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic driver_enable,
  input wire logic low_side_gate,
  input wire logic high_side_gate,
  input wire logic [7:0] trip_len,
  input wire logic [7:0] hi_need,
  input wire logic zc_on,
  output logic aux_zero_crossing,
  output logic switch_node_sense,
  output logic cs_trip
);
  logic [7:0] lo_cnt_q;
  logic [7:0] hi_cnt_q;
  logic [7:0] idle_q;
  logic hi_q;
  logic off;
  assign off = !low_side_gate && !high_side_gate;
  ////////////////////////////////////////////////////////////
  // primary current ramps while the low switch conducts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lo_cnt_q <= 8'h00;
    end else begin
      lo_cnt_q <= low_side_gate ? lo_cnt_q + 8'h01 : 8'h00;
    end
  end
  // last high pulse length decides how far the node discharges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hi_q <= 1'b0;
      hi_cnt_q <= 8'h00;
    end else begin
      hi_q <= high_side_gate;
      if (high_side_gate) begin
        hi_cnt_q <= hi_q ? hi_cnt_q + 8'h01 : 8'h01;
      end
    end
  end
  // ringing crosses zero a few cycles after both switches open
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_q <= 8'h00;
    end else begin
      idle_q <= (off && driver_enable) ? ((idle_q == 8'hff) ? idle_q : idle_q + 8'h01) : 8'h00;
    end
  end
  ////////////////////////////////////////////////////////////
  // trip_len of zero means the peak is never reached
  assign cs_trip = low_side_gate && (trip_len != 8'h00) && (lo_cnt_q >= trip_len);
  assign aux_zero_crossing = zc_on && driver_enable && off && (idle_q >= 8'h03);
  assign switch_node_sense = driver_enable && off && (hi_cnt_q >= hi_need);
endmodule // acfz_drv_model
`default_nettype wire

/* File: testbench/tb.sv */
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import acfz_pkg::*;
  logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
  logic sel = 0, demag = 0, zc_on = 1, aux, snode, trip;
  logic [7:0] paddr = 0, trip_len = 8'h03, hi_need = 8'h00;
  logic [31:0] pwdata = 0, prdata;
  logic [9:0] line = 10'h29a;
  logic pready, pslverr, driver_enable, low_side_gate, high_side_gate, zvth, sense_blank, irq;
  int n_fail = 0, total_checks = 0, seed = 32'ha5fa3953;
  always #50 pclk = ~pclk;
  acfz_sequencer dut_u (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .power_stage_sel(sel), .aux_zero_crossing(aux), .switch_node_sense(snode),
    .cs_trip(trip), .demag_time_resistor_low(demag), .line_sense_current(line),
    .driver_enable(driver_enable), .low_side_gate(low_side_gate), .high_side_gate(high_side_gate),
    .zero_voltage_threshold_high(zvth), .sense_blank(sense_blank), .irq(irq));
  acfz_drv_model drv_u (.pclk(pclk), .presetn(presetn), .driver_enable(driver_enable),
    .low_side_gate(low_side_gate), .high_side_gate(high_side_gate), .trip_len(trip_len),
    .hi_need(hi_need), .zc_on(zc_on), .aux_zero_crossing(aux), .switch_node_sense(snode),
    .cs_trip(trip));
  ////////////////////////////////////////////////////////////
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk("pready", 1, pready);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    logic e;
    apb(1'b0, a, 32'h0, r, e);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] r;
    rd(a, r);
    chk($sformatf("reg_%h", a), x, r);
  endtask
  function automatic logic sig(input int i);
    logic [4:0] v;
    v = {aux, sense_blank, high_side_gate, low_side_gate, driver_enable};
    return v[i];
  endfunction
  task automatic waitv(input int i, input logic v, output int n);
    n = 0;
    while (sig(i) !== v && n < 3000) begin
      @(posedge pclk);
      n++;
    end
  endtask
  task automatic cnt_pulses(output int c);
    int n;
    logic p;
    c = 0;
    n = 0;
    p = 1'b0;
    while (driver_enable === 1'b1 && n < 5000) begin
      if (low_side_gate === 1'b1 && !p) c++;
      p = low_side_gate;
      @(posedge pclk);
      n++;
    end
  endtask
  function automatic logic [31:0] tz_exp(input int tzm, input int i);
    return (i < 666) ? tzm + tzm * (666 - i) * 7 / 3330 : tzm;
  endfunction
  task automatic fault_run(input int lim);
    int n;
    logic [31:0] r;
    trip_len <= 8'h00;
    wr(ADDR_MASK, 32'h1);
    wr(ADDR_CTRL, 32'h1);
    waitv(1, 1'b1, n);
    waitv(1, 1'b0, n);
    chk("fault_len", 1, n >= lim - 1 && n <= lim + 1);
    repeat (3) @(posedge pclk);
    rd(ADDR_STS, r);
    chk("fault_flag", 3'b101, {r[ST_FAULT], driver_enable, irq});
    wr(ADDR_CTRL, 32'h0);
    wr(ADDR_STS, 32'hf);
    repeat (2) @(posedge pclk);
    chk("irq_clr", 0, irq);
    trip_len <= 8'h03;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (60000) @(posedge pclk);
    n_fail++;
    final_report;
  end
  initial begin
    int n, tzm, lv;
    logic [31:0] r;
    logic e;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("outs", 0, {driver_enable, low_side_gate, high_side_gate, zvth});
    rdc(ADDR_CTRL, 32'(CTRL_RST));
    rdc(ADDR_PKT, 32'(PKT_RST));
    rdc(ADDR_TZMIN, 32'(TZMIN_RST));
    rdc(ADDR_MASK, 32'h0);
    rdc(ADDR_STS, 32'h0);
    wr(ADDR_TDM, 32'hffffffff);
    rdc(ADDR_TDM, {20'h0, STEP_RST, TDM_RST});
    rdc(ADDR_INFO, {20'h0, 10'(TZMIN_RST), 2'b10});
    apb(1'b0, 8'h1c, 32'h0, r, e);
    chk("unmapped", 32'h1, {r[30:0], e});
    tzm = 3 + $unsigned($random(seed)) % 8;
    zc_on <= 1'b0;
    wr(ADDR_TZMIN, 32'(tzm));
    wr(ADDR_MASK, 32'hf);
    wr(ADDR_CTRL, 32'h1);
    waitv(0, 1'b1, n);
    waitv(1, 1'b1, n);
    chk("wake_to_low", 1, n >= 43 && n <= 47);
    waitv(3, 1'b0, n);
    chk("blank_lo", 32'(BLANK_LO_CYC), n);
    waitv(1, 1'b0, n);
    waitv(2, 1'b1, n);
    chk("dead_lh", 32'(DLH_CYC), n);
    waitv(2, 1'b0, n);
    chk("hi_on", 32'(TDM_RST), n);
    waitv(1, 1'b1, n);
    chk("dead_hl", tzm, n);
    rd(ADDR_STS, r);
    chk("zc_timeout", 2'b11, {r[ST_ZCTO], irq});
    wr(ADDR_MASK, 32'h0);
    repeat (2) @(posedge pclk);
    chk("irq_mask", 0, irq);
    for (int k = 0; k < 4; k++) begin
      lv = (k == 0) ? 0 : $unsigned($random(seed)) % 700;
      line <= 10'(lv);
      repeat (150) @(posedge pclk);
      rd(ADDR_INFO, r);
      chk("tz_line", tz_exp(tzm, lv), r[11:2]);
    end
    rd(ADDR_TDM, r);
    chk("tdm_min", TDM_MIN, r[7:0]);
    wr(ADDR_STS, 32'hf);
    hi_need <= 8'd20;
    repeat (15) begin
      waitv(2, 1'b1, n);
      waitv(2, 1'b0, n);
    end
    rd(ADDR_STS, r);
    chk("settled", 1, r[ST_SETL]);
    rd(ADDR_TDM, r);
    chk("tdm_near", 1, r[7:0] >= 8'd18 && r[7:0] <= 8'd21);
    wr(ADDR_CTRL, 32'h0);
    waitv(0, 1'b0, n);
    chk("de_off", 1, n >= ZC_CYC && n <= 100);
    line <= 10'h000;
    repeat (20) @(posedge pclk);
    rd(ADDR_INFO, r);
    chk("tz_hold", tz_exp(tzm, lv), r[11:2]);
    zc_on <= 1'b1;
    demag <= 1'b1;
    fault_run(CSF_LO_CYC);
    demag <= 1'b0;
    fault_run(CSF_LO_ALT_CYC);
    for (int k = 0; k < 3; k++) begin
      lv = (k == 0) ? 0 : 1 + $unsigned($random(seed)) % 6;
      wr(ADDR_PKT, 32'(lv));
      wr(ADDR_CTRL, 32'h3);
      waitv(0, 1'b1, n);
      cnt_pulses(n);
      chk("pkt_len", (lv == 0) ? 16 : lv, n);
      waitv(0, 1'b1, n);
      chk("pkt_gap", 1, n >= 21);
      rd(ADDR_STS, r);
      chk("pkt_done", 1, r[ST_PKT]);
      wr(ADDR_CTRL, 32'h0);
      waitv(0, 1'b0, n);
      wr(ADDR_STS, 32'hf);
    end
    trip_len <= 8'h01;
    wr(ADDR_CTRL, 32'h5);
    waitv(1, 1'b1, n);
    waitv(1, 1'b0, n);
    chk("lp_min_on", 1, n >= MINON_LO_CYC);
    n = 0;
    repeat (200) begin
      @(posedge pclk);
      if (high_side_gate !== 1'b0) n++;
    end
    chk("lp_no_high", 0, n);
    ce <= 1'b0;
    @(posedge pclk);
    r = {28'h0, driver_enable, low_side_gate, high_side_gate, sense_blank};
    repeat (5) @(posedge pclk);
    chk("ce_freeze", r, {28'h0, driver_enable, low_side_gate, high_side_gate, sense_blank});
    ce <= 1'b1;
    wr(ADDR_CTRL, 32'h0);
    presetn <= 1'b0;
    sel <= 1'b1;
    trip_len <= 8'h04;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (8) @(posedge pclk);
    sel <= 1'b0;
    rd(ADDR_INFO, r);
    chk("sel_latch", 2'b11, r[1:0]);
    chk("zvth_hi", 1, zvth);
    wr(ADDR_CTRL, 32'h1);
    waitv(1, 1'b1, n);
    waitv(3, 1'b0, n);
    chk("blank_hi", 32'(BLANK_HI_CYC), n);
    waitv(1, 1'b0, n);
    waitv(4, 1'b1, n);
    waitv(2, 1'b1, n);
    chk("zc_to_high", 1, n >= ZCH_CYC && n <= ZCH_CYC + 4);
    wr(ADDR_CTRL, 32'h0);
    waitv(0, 1'b0, n);
    fault_run(CSF_HI_CYC);
    final_report;
  end
endmodule // tb
`default_nettype wire
